/* File: logic/sscap_pkg.sv */
// strap status capture: shared constants, register map and types
package sscap_pkg;

  // register indices as printed; the byte address is four times the index
  localparam logic [15:0] STS1_IDX = 16'h006E;
  localparam logic [15:0] STS2_IDX = 16'h006F;
  localparam logic [15:0] DLY_CTRL_IDX = 16'h0086;
  localparam logic [15:0] DLY_PS_IDX = 16'h0087;

  // first strap status word, bit positions
  localparam int STS1_MIRROR_BIT = 15;
  localparam int STS1_DOWNSHIFT_BIT = 14;
  localparam int STS1_CLKOUT_BIT = 13;
  localparam int STS1_RGIF_BIT = 12;
  localparam int STS1_XOVER_BIT = 10;
  localparam int STS1_PAIRING_BIT = 9;
  localparam int STS1_DUPLEX_BIT = 8;
  localparam int STS1_NEG_BIT = 7;
  localparam int STS1_SPEED_LSB = 5;
  localparam int STS1_ADDR_LSB = 0;

  // second strap status word, bit positions
  localparam int STS2_DROP_BIT = 10;
  localparam int STS2_TXSKEW_LSB = 4;
  localparam int STS2_RXSKEW_LSB = 0;

  // delay control and picosecond register fields
  localparam int DLY_TX_LSB = 4;
  localparam int DLY_RX_LSB = 0;
  localparam int DLY_PS_TX_LSB = 16;
  localparam int DLY_PS_RX_LSB = 0;

  // reset and seed values
  localparam logic [3:0] DLY_LARGE_SEED = 4'h7;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // delay encoding: code 0 is one step, each code adds one step
  localparam int DELAY_STEP_PS_INT = 250;
  localparam logic [11:0] DELAY_STEP_PS = 12'(DELAY_STEP_PS_INT);

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // latched strap levels
  typedef struct packed {
    logic mirror;
    logic downshift;
    logic clockOutputOff;
    logic reducedGigIfOff;
    logic autoCrossoverOff;
    logic forcedPairing;
    logic halfDuplex;
    logic negotiationOff;
    logic [1:0] speedChoice;
    logic [4:0] stationAddress;
    logic quickDrop;
    logic [2:0] txSkew;
    logic [2:0] rxSkew;
  } sscap_straps_t;

endpackage

/* File: logic/sscap_strap_if.sv */
// strap status capture: latched strap values passed from latch to register bank
`timescale 1ns/10ps
interface sscap_strap_if;
  import sscap_pkg::*;
  sscap_straps_t latched;
  logic captured;
  modport source (output latched, output captured);
  modport sink (input latched, input captured);
endinterface

/* File: logic/sscap_latch.sv */
// strap status capture: one-time strap latch after reset release
`timescale 1ns/10ps
module sscap_latch
  import sscap_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // strap pin levels
  input wire sscap_straps_t pinsIn,
  // latched values
  sscap_strap_if.source strapOut
);

  typedef struct packed {
    logic captured;
    sscap_straps_t straps;
  } sscap_latch_state_t;

  sscap_latch_state_t state_q;
  sscap_latch_state_t state_d;

  // sample once on the first edge after release, then hold until next reset
  always_comb begin
    state_d = state_q;
    if (!state_q.captured) begin
      state_d.captured = 1'b1;
      state_d.straps = pinsIn;
    end
  end

  // async reset loads constants only; pins are caught by the clocked path
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign strapOut.latched = state_q.straps;
  assign strapOut.captured = state_q.captured;

endmodule

/* File: logic/sscap_delay_ps.sv */
// strap status capture: delay code to picoseconds, one lane per channel
`timescale 1ns/10ps
module sscap_delay_ps
  import sscap_pkg::*;
#(
  parameter int LANES = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // four-bit delay codes
  input wire logic [LANES*4-1:0] codeIn,
  // delay in picoseconds, registered
  output logic [LANES*12-1:0] psOut
);

  typedef struct packed {
    logic [LANES*12-1:0] ps;
  } sscap_delay_state_t;

  sscap_delay_state_t state_q;
  sscap_delay_state_t state_d;
  wire [LANES*12-1:0] lanePs;

  // code n means (n + 1) steps of a quarter nanosecond
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign lanePs[i*12 +: 12] = 12'(({8'h00, codeIn[i*4 +: 4]} + 12'h001) * DELAY_STEP_PS);
  end

  // one process owns the whole next state, lanes only feed it
  always_comb begin
    state_d.ps = lanePs;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign psOut = state_q.ps;

endmodule

/* File: logic/sscap_top.sv */
// strap status capture: axi4-lite register bank reporting latched straps
`timescale 1ns/10ps
module sscap_top
  import sscap_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter bit LARGE_PKG = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // strap pins, level at reset release
  input wire logic strapMirror,
  input wire logic strapDownshift,
  input wire logic strapClockOutputOff,
  input wire logic strapReducedGigIfOff,
  input wire logic strapAutoCrossoverOff,
  input wire logic strapForcedPairing,
  input wire logic strapHalfDuplex,
  input wire logic strapNegotiationOff,
  input wire logic [1:0] strapSpeedChoice,
  input wire logic [4:0] strapStationAddress,
  input wire logic strapQuickDrop,
  input wire logic [2:0] strapTxSkew,
  input wire logic [2:0] strapRxSkew,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // every register is one aligned word, so the two low address bits are dropped
  localparam int IDX_W = ADDR_W - 2;

  ////////////////////////////////////////////////////////////////////////////
  // strap latch and delay conversion

  // the latch owns the strap snapshot; this block only reads it
  sscap_strap_if strapBus ();
  sscap_straps_t pinLevels;
  logic [7:0] delayCodes;
  logic [23:0] delayPs;

  // gather pins into one word for the latch
  always_comb begin
    pinLevels.mirror = strapMirror;
    pinLevels.downshift = strapDownshift;
    pinLevels.clockOutputOff = strapClockOutputOff;
    pinLevels.reducedGigIfOff = strapReducedGigIfOff;
    pinLevels.autoCrossoverOff = strapAutoCrossoverOff;
    pinLevels.forcedPairing = strapForcedPairing;
    pinLevels.halfDuplex = strapHalfDuplex;
    pinLevels.negotiationOff = strapNegotiationOff;
    pinLevels.speedChoice = strapSpeedChoice;
    pinLevels.stationAddress = strapStationAddress;
    pinLevels.quickDrop = strapQuickDrop;
    pinLevels.txSkew = strapTxSkew;
    pinLevels.rxSkew = strapRxSkew;
  end

  sscap_latch u_latch (
    .clk(clk),
    .rst_n(rst_n),
    .pinsIn(pinLevels),
    .strapOut(strapBus.source)
  );

  sscap_delay_ps #(
    .LANES(2)
  ) u_delay (
    .clk(clk),
    .rst_n(rst_n),
    .codeIn(delayCodes),
    .psOut(delayPs)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic seeded;
    logic [3:0] txCode;
    logic [3:0] rxCode;
    logic awReady;
    // write address and data wait here until both halves have arrived
    logic awHeld;
    logic [IDX_W-1:0] awIdx;
    logic wReady;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } sscap_top_state_t;

  sscap_top_state_t state_q;
  sscap_top_state_t state_d;

  ////////////////////////////////////////////////////////////////////////////
  // status words built from latched straps

  sscap_straps_t lat;
  logic [15:0] statusOne;
  logic [15:0] statusTwo;

  assign lat = strapBus.latched;

  // unused bits stay zero, including the variant-dependent reserved ones
  always_comb begin
    statusOne = 16'h0000;
    statusOne[STS1_MIRROR_BIT] = lat.mirror;
    statusOne[STS1_DOWNSHIFT_BIT] = lat.downshift;
    statusOne[STS1_CLKOUT_BIT] = LARGE_PKG ? lat.clockOutputOff : 1'b0;
    statusOne[STS1_RGIF_BIT] = lat.reducedGigIfOff;
    statusOne[STS1_XOVER_BIT] = lat.autoCrossoverOff;
    statusOne[STS1_PAIRING_BIT] = lat.forcedPairing;
    statusOne[STS1_DUPLEX_BIT] = lat.halfDuplex;
    statusOne[STS1_NEG_BIT] = lat.negotiationOff;
    if (LARGE_PKG) begin
      statusOne[STS1_SPEED_LSB +: 2] = lat.speedChoice;
      statusOne[STS1_ADDR_LSB +: 5] = lat.stationAddress;
    end else begin
      statusOne[STS1_SPEED_LSB] = lat.speedChoice[0];
      statusOne[STS1_ADDR_LSB +: 4] = lat.stationAddress[3:0];
    end
    statusTwo = 16'h0000;
    statusTwo[STS2_DROP_BIT] = lat.quickDrop;
    if (!LARGE_PKG) begin
      statusTwo[STS2_TXSKEW_LSB +: 3] = lat.txSkew;
      statusTwo[STS2_RXSKEW_LSB +: 3] = lat.rxSkew;
    end
  end

  // the picosecond view trails the codes by one cycle
  assign delayCodes = {state_q.txCode, state_q.rxCode};

  ////////////////////////////////////////////////////////////////////////////
  // read decode

  logic [IDX_W-1:0] arIdx;
  logic [31:0] readWord;
  logic readHit;

  // decoded live, so the read address must stand until arready is seen
  assign arIdx = s_axi_araddr[ADDR_W-1:2];

  // 16-bit registers sit in the low half, upper half reads zero
  always_comb begin
    readWord = RDATA_RESET;
    readHit = 1'b1;
    if (arIdx == STS1_IDX[IDX_W-1:0]) begin
      readWord = {16'h0000, statusOne};
    end else if (arIdx == STS2_IDX[IDX_W-1:0]) begin
      readWord = {16'h0000, statusTwo};
    end else if (arIdx == DLY_CTRL_IDX[IDX_W-1:0]) begin
      readWord[DLY_TX_LSB +: 4] = state_q.txCode;
      readWord[DLY_RX_LSB +: 4] = state_q.rxCode;
    end else if (arIdx == DLY_PS_IDX[IDX_W-1:0]) begin
      readWord[DLY_PS_TX_LSB +: 12] = delayPs[23:12];
      readWord[DLY_PS_RX_LSB +: 12] = delayPs[11:0];
    end else begin
      readHit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic writeFire;
  logic writeHit;

  always_comb begin
    state_d = state_q;
    writeFire = 1'b0;
    writeHit = 1'b0;

    // seed delay codes from straps once the latch has them
    // the larger layout has no skew straps, so both codes start mid-range
    if (strapBus.captured && !state_q.seeded) begin
      state_d.seeded = 1'b1;
      if (LARGE_PKG) begin
        state_d.txCode = DLY_LARGE_SEED;
        state_d.rxCode = DLY_LARGE_SEED;
      end else begin
        state_d.txCode = {1'b0, lat.txSkew};
        state_d.rxCode = {1'b0, lat.rxSkew};
      end
    end

    // address and data are taken independently, in either order
    if (s_axi_awvalid && state_q.awReady) begin
      state_d.awHeld = 1'b1;
      state_d.awIdx = s_axi_awaddr[ADDR_W-1:2];
    end
    if (s_axi_wvalid && state_q.wReady) begin
      state_d.wHeld = 1'b1;
      state_d.wData = s_axi_wdata;
      state_d.wStrb = s_axi_wstrb;
    end

    // perform the write once both halves are held
    if (state_q.awHeld && state_q.wHeld && !state_q.bValid) begin
      writeFire = 1'b1;
      state_d.awHeld = 1'b0;
      state_d.wHeld = 1'b0;
      state_d.bValid = 1'b1;
      // status words accept the write but keep the strap values
      writeHit = (state_q.awIdx == STS1_IDX[IDX_W-1:0]) ||
                 (state_q.awIdx == STS2_IDX[IDX_W-1:0]) ||
                 (state_q.awIdx == DLY_CTRL_IDX[IDX_W-1:0]) ||
                 (state_q.awIdx == DLY_PS_IDX[IDX_W-1:0]);
      state_d.bResp = writeHit ? RESP_OKAY : RESP_SLVERR;
      // both delay codes live in the low byte lane
      if (state_q.awIdx == DLY_CTRL_IDX[IDX_W-1:0] && state_q.wStrb[0]) begin
        state_d.txCode = state_q.wData[DLY_TX_LSB +: 4];
        state_d.rxCode = state_q.wData[DLY_RX_LSB +: 4];
      end
    end
    if (state_q.bValid && s_axi_bready) begin
      state_d.bValid = 1'b0;
    end

    // one write at a time: no new address or data until the response is gone
    state_d.awReady = state_d.seeded && !state_d.awHeld && !state_d.bValid && !writeFire;
    state_d.wReady = state_d.seeded && !state_d.wHeld && !state_d.bValid && !writeFire;

    // read: answer is registered in the cycle the address is taken
    // reads never wait on the write path, the two run independently
    if (s_axi_arvalid && state_q.arReady) begin
      state_d.rValid = 1'b1;
      state_d.rData = readWord;
      state_d.rResp = readHit ? RESP_OKAY : RESP_SLVERR;
    end else if (state_q.rValid && s_axi_rready) begin
      state_d.rValid = 1'b0;
    end
    state_d.arReady = state_d.seeded && !state_d.rValid;
  end

  // ready stays low until the straps are latched and seeded, so no read
  // can ever see pre-capture zeros
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops
  // protection bits are accepted and ignored; every access has the same rights

  assign s_axi_awready = state_q.awReady;
  assign s_axi_wready = state_q.wReady;
  assign s_axi_bvalid = state_q.bValid;
  assign s_axi_bresp = state_q.bResp;
  assign s_axi_arready = state_q.arReady;
  assign s_axi_rvalid = state_q.rValid;
  assign s_axi_rdata = state_q.rData;
  assign s_axi_rresp = state_q.rResp;

endmodule

/* File: testbench/sscap_top_monitor.sv */
// strap status capture: port checker bound to the top module
`timescale 1ns/10ps
module sscap_top_monitor
  import sscap_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter bit LARGE_PKG = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // strap pins
  input wire logic strapMirror,
  input wire logic strapDownshift,
  input wire logic strapClockOutputOff,
  input wire logic strapReducedGigIfOff,
  input wire logic strapAutoCrossoverOff,
  input wire logic strapForcedPairing,
  input wire logic strapHalfDuplex,
  input wire logic strapNegotiationOff,
  input wire logic [1:0] strapSpeedChoice,
  input wire logic [4:0] strapStationAddress,
  input wire logic strapQuickDrop,
  input wire logic [2:0] strapTxSkew,
  input wire logic [2:0] strapRxSkew,
  // register bus
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam logic [ADDR_W-1:0] A1 = ADDR_W'({STS1_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] A2 = ADDR_W'({STS2_IDX, 2'b00});
  logic armed_q;
  logic [15:0] exp1_q;
  logic [15:0] exp2_q;
  logic [ADDR_W-1:0] rdAddr_q;
  logic [ADDR_W-1:0] wrAddr_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////////
  // pin snapshot at the first edge after release; later pin motion must not leak
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= 1'b1;
      if (!armed_q) begin
        exp1_q <= {strapMirror, strapDownshift, LARGE_PKG & strapClockOutputOff,
          strapReducedGigIfOff, 1'b0, strapAutoCrossoverOff, strapForcedPairing,
          strapHalfDuplex, strapNegotiationOff,
          LARGE_PKG ? strapSpeedChoice : {1'b0, strapSpeedChoice[0]},
          LARGE_PKG ? strapStationAddress : {1'b0, strapStationAddress[3:0]}};
        exp2_q <= {5'h00, strapQuickDrop, 3'h0, LARGE_PKG ? 3'h0 : strapTxSkew, 1'b0,
          LARGE_PKG ? 3'h0 : strapRxSkew};
      end
      if (s_axi_arvalid && s_axi_arready) rdAddr_q <= s_axi_araddr;
      if (s_axi_awvalid && s_axi_awready) wrAddr_q <= s_axi_awaddr;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  AST_STS1: assert property (s_axi_rvalid && rdAddr_q == A1 |->
    s_axi_rdata == {16'h0000, exp1_q} && s_axi_rresp == RESP_OKAY) else $error("status one");
  AST_STS2: assert property (s_axi_rvalid && rdAddr_q == A2 |->
    s_axi_rdata == {16'h0000, exp2_q}) else $error("status two");
  AST_RO_WRITE: assert property (s_axi_bvalid && (wrAddr_q == A1 || wrAddr_q == A2)
    |-> s_axi_bresp == RESP_OKAY) else $error("status write response");
  AST_UNMAPPED: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
    |-> s_axi_rdata == 32'h0000_0000) else $error("refused read data");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("read answer");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read hold");
  AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer");
  AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write hold");
  // main scenarios
  cover property (s_axi_rvalid && s_axi_rready && rdAddr_q == A1);
  cover property (s_axi_bvalid && s_axi_bready && wrAddr_q == A1);
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule
bind sscap_top sscap_top_monitor #(.ADDR_W(ADDR_W), .LARGE_PKG(LARGE_PKG)) i_mon (.*);

/* File: testbench/sscap_strap_board.sv */
// strap status capture: board strap resistors, one fixed level per pin
`timescale 1ns/10ps
module sscap_strap_board (
  // fitted resistor pattern
  input wire logic [21:0] fit,
  // pin levels
  output logic strapMirror,
  output logic strapDownshift,
  output logic strapClockOutputOff,
  output logic strapReducedGigIfOff,
  output logic strapAutoCrossoverOff,
  output logic strapForcedPairing,
  output logic strapHalfDuplex,
  output logic strapNegotiationOff,
  output logic [1:0] strapSpeedChoice,
  output logic [4:0] strapStationAddress,
  output logic strapQuickDrop,
  output logic [2:0] strapTxSkew,
  output logic [2:0] strapRxSkew
);
  // resistors never float, so every pin simply shows its fitted level
  assign {strapMirror, strapDownshift, strapClockOutputOff, strapReducedGigIfOff,
    strapAutoCrossoverOff, strapForcedPairing, strapHalfDuplex, strapNegotiationOff,
    strapSpeedChoice, strapStationAddress, strapQuickDrop, strapTxSkew, strapRxSkew} = fit;
endmodule

/* File: testbench/tb.sv */
// strap status capture: self-checking bench over the register bus
`timescale 1ns/10ps
module tb;
  import sscap_pkg::*;
  localparam logic [11:0] A1 = {STS1_IDX[9:0], 2'b00};
  localparam logic [11:0] A2 = {STS2_IDX[9:0], 2'b00};
  localparam logic [11:0] A3 = {DLY_CTRL_IDX[9:0], 2'b00};
  localparam logic [11:0] A4 = {DLY_PS_IDX[9:0], 2'b00};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [21:0] fit = '0;
  logic [21:0] p;
  logic strapMirror, strapDownshift, strapClockOutputOff, strapReducedGigIfOff;
  logic strapAutoCrossoverOff, strapForcedPairing, strapHalfDuplex, strapNegotiationOff;
  logic strapQuickDrop;
  logic [1:0] strapSpeedChoice;
  logic [4:0] strapStationAddress;
  logic [2:0] strapTxSkew, strapRxSkew;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d, ds;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic smAwready, smWready, smBvalid, smArready, smRvalid;
  logic [1:0] smBresp, smRresp;
  logic [31:0] smRdata;
  int miscompares = 0;
  int checks = 0;
  sscap_strap_board i_board (.*);
  sscap_top i_dut (.*);
  // second device in the smaller package layout, fed the same pins and requests
  sscap_top #(
    .LARGE_PKG(1'b0)
  ) i_dut_small (
    .*,
    .s_axi_awready(smAwready),
    .s_axi_wready(smWready),
    .s_axi_bresp(smBresp),
    .s_axi_bvalid(smBvalid),
    .s_axi_arready(smArready),
    .s_axi_rdata(smRdata),
    .s_axi_rresp(smRresp),
    .s_axi_rvalid(smRvalid)
  );
  always #25 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask
  // bus write; each valid drops at the edge that took it
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    ds = smRdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  // pins settle under reset so the first edge after release latches them
  task automatic boot(input logic [21:0] v);
    p = v;
    rst_n <= 1'b0;
    fit <= v;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [31:0] sts1(input logic [21:0] v);
    return {16'h0000, v[21:18], 1'b0, v[17:7]};
  endfunction
  function automatic logic [31:0] sts2(input logic [21:0] v);
    return {21'h000000, v[6], 10'h000};
  endfunction
  // smaller layout: no clock output bit, one speed bit, four address bits, skews shown
  function automatic logic [31:0] sts1s(input logic [21:0] v);
    return {16'h0000, v[21:20], 1'b0, v[18], 1'b0, v[17:14], 1'b0, v[12], 1'b0, v[10:7]};
  endfunction
  function automatic logic [31:0] sts2s(input logic [21:0] v);
    return {21'h000000, v[6], 3'h0, v[5:3], 1'b0, v[2:0]};
  endfunction
  function automatic logic [11:0] ps(input logic [3:0] c);
    return 12'((int'(c) + 1) * 250);
  endfunction
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // two opposite patterns give every strap both levels, second reset mid-run
  initial begin
    for (int k = 0; k < 2; k++) begin
      boot(k ? 22'h155555 : 22'h2AAAAA);
      fit <= ~p;
      rd(A1);
      chk("status one", d, sts1(p));
      chk("small status one", ds, sts1s(p));
      rd(A2);
      chk("status two", d, sts2(p));
      chk("small status two", ds, sts2s(p));
      wr(A1, 32'hFFFFFFFF);
      chk("status one write resp", 32'(r), 32'(RESP_OKAY));
      wr(A2, 32'hFFFFFFFF);
      rd(A1);
      chk("status one after write", d, sts1(p));
      rd(A2);
      chk("status two after write", d, sts2(p));
      chk("small status two after write", ds, sts2s(p));
      $display("strap pattern %0d done", k);
    end
    rd(A4);
    chk("seeded delay", d, {4'h0, ps(DLY_LARGE_SEED), 4'h0, ps(DLY_LARGE_SEED)});
    chk("small seeded delay", ds, {4'h0, ps({1'b0, p[5:3]}), 4'h0, ps({1'b0, p[2:0]})});
    for (int c = 0; c < 16; c += 7) begin
      wr(A3, {24'h000000, 4'(c), ~4'(c)});
      repeat (2) @(posedge clk);
      rd(A4);
      chk("delay ps", d, {4'h0, ps(4'(c)), 4'h0, ps(~4'(c))});
      chk("small delay ps", ds, {4'h0, ps(4'(c)), 4'h0, ps(~4'(c))});
    end
    $display("delay test done");
    rd(12'hFFC);
    chk("unmapped read data", d, 32'h00000000);
    chk("unmapped read resp", 32'(r), 32'(RESP_SLVERR));
    wr(12'hFFC, 32'h00000001);
    chk("unmapped write resp", 32'(r), 32'(RESP_SLVERR));
    $display("unmapped test done");
    end_of_test();
  end
  // watchdog, well beyond the hundred or so cycles the tests take
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
endmodule
